// ---- rtl/fswdt_top.sv ----
// Watchdog timer with APB register access, prewarning interrupt and reset request.
// Assumes CPU command pulses synchronous to REF_CLK and an APB master on the same clock.
//
// Chosen here: the APB slave port and the placing of the registers.
`include "fswdt_regs.svh"

// Contract
// - After every reset the watchdog is enabled and counting with no software action.
// - The disable command stops counting at any time; the enable command resumes it only while no overflow has occurred.
// - An overflow raises the prewarning interrupt first and the reset request after it.
// - The count is sixteen bits wide and overflow is the wrap beyond all ones.
// - The count advances once per prescaler period of 16384 or 256 clocks.
// - Every restart loads the count from the software-programmable reload value.
// - A service reloads the count and clears the prescaler for a full period.
// - Reset defaults give an overflow interval of about 6.5 ms at a 10 MHz clock.
module fswdt_top (
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // CPU commands.
  input  wire logic        WATCHDOG_SERVICE_CMD,
  input  wire logic        WATCHDOG_DISABLE_CMD,
  input  wire logic        WATCHDOG_ENABLE_CMD,
  // System outputs.
  output logic             IRQ,
  output logic             RESET_REQ
);
  import fswdt_pkg::*;

  fswdt_state_type  state_q;
  fswdt_state_type  state_d;
  fswdt_count_type  watchdog_reload_value_q;
  fswdt_count_type  count;
  logic             en_q;
  logic             slow_sel_q;
  logic [1:0]       status_q;
  logic [1:0]       status_d;
  logic [1:0]       mask_q;
  logic [9:0]       warn_cnt_q;
  logic [9:0]       warn_cnt_d;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;
  logic             irq_q;
  logic             reset_req_q;
  logic             boot_q;
  logic             tick;
  logic             ovf;

  // Bus decode.
  wire access    = PSEL && PENABLE;
  wire first_acc = access && !pready_q;
  wire wr_fire   = access && pready_q && PWRITE;
  wire hit_ctrl  = (PADDR == `FSWDT_ADDR_CTRL);
  wire hit_rel   = (PADDR == `FSWDT_ADDR_RELOAD);
  wire hit_cnt   = (PADDR == `FSWDT_ADDR_COUNT);
  wire hit_stat  = (PADDR == `FSWDT_ADDR_STATUS);
  wire hit_mask  = (PADDR == `FSWDT_ADDR_MASK);
  wire mapped    = hit_ctrl || hit_rel || hit_cnt || hit_stat || hit_mask;
  wire wr_ctrl   = wr_fire && hit_ctrl;
  wire wr_rel    = wr_fire && hit_rel;
  wire wr_stat   = wr_fire && hit_stat;
  wire wr_mask   = wr_fire && hit_mask;

  wire [31:0] ctrl_rd = {30'h00000000, en_q, slow_sel_q};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_rel  ? {16'h0000, watchdog_reload_value_q} :
                        hit_cnt  ? {16'h0000, count} :
                        hit_stat ? {30'h00000000, status_q} :
                        hit_mask ? {30'h00000000, mask_q} : 32'h00000000;

  // Watchdog control.
  wire running  = (state_q == FSWDT_RUN);
  wire svc      = running && WATCHDOG_SERVICE_CMD;
  wire sel_chg  = wr_ctrl && (PWDATA[`FSWDT_CTRL_SEL_BIT] != slow_sel_q);
  wire pre_clr  = svc || sel_chg;
  wire count_en = running && en_q;
  wire warn_end = (warn_cnt_q == 10'h000);

  // Event flags: hardware set wins over a software clear.
  wire [1:0] ev_set = {(state_q == FSWDT_WARN) && warn_end, ovf};
  wire [1:0] ev_clr = wr_stat ? PWDATA[1:0] : 2'h0;
  wire [1:0] mask_d = wr_mask ? PWDATA[1:0] : mask_q;

  assign status_d = (status_q & ~ev_clr) | ev_set;

  always_comb begin
    state_d    = state_q;
    warn_cnt_d = warn_cnt_q;
    unique case (state_q)
      FSWDT_RUN: begin
        if (ovf) begin
          state_d    = FSWDT_WARN;
          warn_cnt_d = `FSWDT_WARN_CYCLES;
        end
      end
      FSWDT_WARN: begin
        if (warn_end) begin
          state_d = FSWDT_RESET;
        end else begin
          warn_cnt_d = warn_cnt_q - 10'h001;
        end
      end
      FSWDT_RESET: begin
        state_d = FSWDT_RESET;
      end
      default: begin
        state_d = FSWDT_RESET;
      end
    endcase
  end

  fswdt_prescaler u_prescaler (
    .clk      (REF_CLK),
    .arst_n   (ARST_N),
    .run      (count_en),
    .clr      (pre_clr),
    .slow_sel (slow_sel_q),
    .tick_q   (tick)
  );

  fswdt_counter u_counter (
    .clk     (REF_CLK),
    .arst_n  (ARST_N),
    .load    (svc),
    .inc     (count_en && tick),
    .reload  (watchdog_reload_value_q),
    .count_q (count),
    .ovf     (ovf)
  );

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_q <= 1'b1;
    end else if (WATCHDOG_DISABLE_CMD) begin
      en_q <= 1'b0;
    end else if (WATCHDOG_ENABLE_CMD) begin
      en_q <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q    <= FSWDT_RUN;
      warn_cnt_q <= 10'h000;
    end else begin
      state_q    <= state_d;
      warn_cnt_q <= warn_cnt_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      watchdog_reload_value_q <= `FSWDT_RELOAD_RST;
      slow_sel_q              <= `FSWDT_SEL_RST;
      mask_q                  <= `FSWDT_MASK_RST;
    end else begin
      if (wr_rel) begin
        watchdog_reload_value_q <= PWDATA[15:0];
      end
      if (wr_ctrl) begin
        slow_sel_q <= PWDATA[`FSWDT_CTRL_SEL_BIT];
      end
      if (wr_mask) begin
        mask_q <= PWDATA[1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_q    <= 2'h0;
      irq_q       <= 1'b0;
      reset_req_q <= 1'b0;
      boot_q      <= 1'b1;
    end else begin
      status_q    <= status_d;
      irq_q       <= |(status_d & mask_d);
      reset_req_q <= reset_req_q || ev_set[`FSWDT_STAT_RST_BIT];
      boot_q      <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= first_acc;
      pslverr_q <= first_acc && !mapped;
      if (first_acc && !PWRITE) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign PRDATA    = prdata_q;
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;
  assign IRQ       = irq_q;
  assign RESET_REQ = reset_req_q;

  // Checks.
  a_boot_armed: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    boot_q |-> en_q && running)
    else $error("Watchdog not armed after reset.");

  a_boot_defaults: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    boot_q |-> watchdog_reload_value_q == `FSWDT_RELOAD_RST && slow_sel_q == `FSWDT_SEL_RST)
    else $error("Reset defaults wrong.");

  a_disable_stop: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    WATCHDOG_DISABLE_CMD |=> !en_q ##1 (!en_q && !svc) [*2] |-> $stable(count))
    else $error("Counter moved while disabled.");

  a_enable_resume: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    WATCHDOG_ENABLE_CMD && !WATCHDOG_DISABLE_CMD |=> en_q)
    else $error("Enable command not taken next cycle.");

  a_service_reload: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    svc |=> count == $past(watchdog_reload_value_q))
    else $error("Service did not reload the counter.");

  a_ovf_wrap: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ovf |-> count == `FSWDT_COUNT_MAX ##1 status_q[`FSWDT_STAT_WARN_BIT])
    else $error("Overflow not at all ones or prewarning lost.");

  a_warn_first: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $rose(reset_req_q) |-> $past(state_q) == FSWDT_WARN && $past(warn_cnt_q) == 10'h000)
    else $error("Reset request without prewarning delay.");

  a_warn_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ovf |=> !reset_req_q [*8])
    else $error("Reset request came too soon.");

  a_irq_level: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    |(status_q & mask_q) |-> irq_q)
    else $error("Interrupt low with an unmasked flag.");

  a_irq_quiet: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !(|(status_q & mask_q)) |-> !irq_q)
    else $error("Interrupt high with no unmasked flag.");

  a_disable_next: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    WATCHDOG_DISABLE_CMD |=> !en_q)
    else $error("Disable command not taken next cycle.");

  a_enable_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !WATCHDOG_DISABLE_CMD && !WATCHDOG_ENABLE_CMD |=> en_q == $past(en_q))
    else $error("Enable state changed without a command.");

  a_count_frozen: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !count_en && !svc |=> $stable(count))
    else $error("Counter moved while not counting.");

  a_tick_gated: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !count_en |=> !tick)
    else $error("Prescaler ticked while stopped.");

  a_reload_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_rel |=> watchdog_reload_value_q == $past(PWDATA[15:0]))
    else $error("Reload value not stored.");

  a_select_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    wr_ctrl |=> slow_sel_q == $past(PWDATA[`FSWDT_CTRL_SEL_BIT]))
    else $error("Prescaler select not stored.");

  a_warn_load: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ovf |=> state_q == FSWDT_WARN && warn_cnt_q == `FSWDT_WARN_CYCLES)
    else $error("Prewarning delay not started.");

  a_warn_step: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    state_q == FSWDT_WARN && !warn_end |=> state_q == FSWDT_WARN &&
      warn_cnt_q == $past(warn_cnt_q) - 10'h001)
    else $error("Prewarning delay did not step down.");

  a_reset_hold: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    state_q == FSWDT_RESET |=> state_q == FSWDT_RESET && reset_req_q)
    else $error("Reset request state left.");

  a_reset_flag: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ev_set[`FSWDT_STAT_RST_BIT] |=> status_q[`FSWDT_STAT_RST_BIT] && reset_req_q)
    else $error("Reset request flag or output missing.");

  a_halt_after_ovf: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !running |=> $stable(count) && !tick)
    else $error("Counter moved after overflow.");

  a_service_refused: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !running && WATCHDOG_SERVICE_CMD |=> !running)
    else $error("Service cancelled the overflow sequence.");

  a_boot_count: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    boot_q |-> count == `FSWDT_RELOAD_RST)
    else $error("Counter not at its reset value.");

endmodule : fswdt_top

// ---- shared/fswdt_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes a 32-bit APB slave with 12-bit byte addresses, one register per word.
`ifndef FSWDT_REGS_SVH
`define FSWDT_REGS_SVH

`define FSWDT_ADDR_CTRL       12'h000
`define FSWDT_ADDR_RELOAD     12'h004
`define FSWDT_ADDR_COUNT      12'h008
`define FSWDT_ADDR_STATUS     12'h00C
`define FSWDT_ADDR_MASK       12'h010

`define FSWDT_CTRL_SEL_BIT    0
`define FSWDT_CTRL_EN_BIT     1
`define FSWDT_STAT_WARN_BIT   0
`define FSWDT_STAT_RST_BIT    1

`define FSWDT_RELOAD_RST      16'hFF00
`define FSWDT_SEL_RST         1'b0
`define FSWDT_MASK_RST        2'h3
`define FSWDT_COUNT_MAX       16'hFFFF

`define FSWDT_DIV_FAST_LIM    14'h00FF
`define FSWDT_DIV_SLOW_LIM    14'h3FFF
`define FSWDT_WARN_CYCLES     10'h100

`endif

// ---- shared/fswdt_pkg.sv ----
// Types shared by the watchdog design files.
// Assumes nothing of its surroundings.
package fswdt_pkg;

  typedef enum logic [1:0] {
    FSWDT_RUN,
    FSWDT_WARN,
    FSWDT_RESET
  } fswdt_state_type;

  typedef logic [15:0] fswdt_count_type;

endpackage : fswdt_pkg

// ---- rtl/fswdt_prescaler.sv ----
// Prescaler of the watchdog: a one-cycle tick every 256 or 16384 clocks.
// Assumes one clock; clear restarts a full period.
`include "fswdt_regs.svh"

module fswdt_prescaler (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  // Control.
  input  wire logic run,
  input  wire logic clr,
  input  wire logic slow_sel,
  // Tick out.
  output logic      tick_q
);
  import fswdt_pkg::*;

  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  wire  [13:0] lim  = slow_sel ? `FSWDT_DIV_SLOW_LIM : `FSWDT_DIV_FAST_LIM;
  wire         wrap = (cnt_q >= lim);

  assign cnt_d = clr ? 14'h0000 : (!run ? cnt_q : (wrap ? 14'h0000 : cnt_q + 14'h0001));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 14'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= !clr && run && wrap;
    end
  end

  a_tick_period: assert property (@(posedge clk) disable iff (!arst_n)
    tick_q |-> $past(cnt_q) == $past(lim))
    else $error("Prescaler tick without a full period.");

  a_clear_next: assert property (@(posedge clk) disable iff (!arst_n)
    clr |=> (cnt_q == 14'h0000) && !tick_q)
    else $error("Prescaler not cleared in the next cycle.");

endmodule : fswdt_prescaler

// ---- rtl/fswdt_counter.sv ----
// Sixteen-bit up counter of the watchdog with reload and overflow flag.
// Assumes one clock; load takes priority over increment.
`include "fswdt_regs.svh"

module fswdt_counter (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Control.
  input  wire logic                      load,
  input  wire logic                      inc,
  input  wire fswdt_pkg::fswdt_count_type reload,
  // State.
  output fswdt_pkg::fswdt_count_type     count_q,
  output logic                           ovf
);
  import fswdt_pkg::*;

  wire at_max = (count_q == `FSWDT_COUNT_MAX);

  assign ovf = !load && inc && at_max;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= `FSWDT_RELOAD_RST;
    end else if (load || ovf) begin
      count_q <= reload;
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
    inc && !load && !at_max |=> count_q == $past(count_q) + 16'h0001)
    else $error("Counter did not step by one.");

endmodule : fswdt_counter

// ---- testbench/fswdt_cpu_model.sv ----
// Model of the CPU core: turns bench requests into one-cycle command pulses.
// Assumes one clock; with auto_en high it services every PERIOD+1 clocks.
module fswdt_cpu_model #(
  parameter int PERIOD = 200
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  // Requests from the bench.
  input  wire logic auto_en,
  input  wire logic svc_req,
  input  wire logic dis_req,
  input  wire logic en_req,
  // Commands to the watchdog.
  output logic      svc_cmd,
  output logic      dis_cmd,
  output logic      en_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tmr_q;
  wire         due = auto_en && (tmr_q == 16'(PERIOD));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q   <= 16'h0000;
      svc_cmd <= 1'b0;
      dis_cmd <= 1'b0;
      en_cmd  <= 1'b0;
    end else begin
      tmr_q   <= (auto_en && !due) ? tmr_q + 16'h0001 : 16'h0000;
      svc_cmd <= svc_req | due;
      dis_cmd <= dis_req;
      en_cmd  <= en_req;
    end
  end
endmodule : fswdt_cpu_model

// ---- testbench/fswdt_top_test.sv ----
// Self-checking bench of the watchdog: APB master, command model and checks.
// Assumes fswdt_top and fswdt_cpu_model on one 250 MHz clock.
`include "fswdt_regs.svh"

module fswdt_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fswdt_pkg::*;
  logic            clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, rst_req, er;
  logic            auto_en, svc_req, dis_req, en_req, svc_cmd, dis_cmd, en_cmd;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd, keep;
  int              miscompares, samples_checked, n;
  fswdt_count_type rl;
  logic [31:0]     rst_tab [6] = '{32'h2, 32'hFF00, 32'hFF00, 32'h0, 32'h3, 32'h0};

  fswdt_top dut (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .WATCHDOG_SERVICE_CMD(svc_cmd), .WATCHDOG_DISABLE_CMD(dis_cmd),
    .WATCHDOG_ENABLE_CMD(en_cmd), .IRQ(irq), .RESET_REQ(rst_req));
  fswdt_cpu_model #(.PERIOD(200)) cpu (.clk(clk), .arst_n(arst_n), .auto_en(auto_en),
    .svc_req(svc_req), .dis_req(dis_req), .en_req(en_req), .svc_cmd(svc_cmd),
    .dis_cmd(dis_cmd), .en_cmd(en_cmd));

  always #2 clk = ~clk;

  function automatic fswdt_count_type exp_cnt(input fswdt_count_type r, input int t);
    return r + 16'(t);
  endfunction : exp_cnt

  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", w, e, s);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic s, input logic d, input logic e);
    @(posedge clk);
    svc_req <= s;
    dis_req <= d;
    en_req  <= e;
    @(posedge clk);
    svc_req <= 1'b0;
    dis_req <= 1'b0;
    en_req  <= 1'b0;
  endtask : cmd

  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  initial begin
    {clk, arst_n, psel, penable, pwrite, auto_en, svc_req, dis_req, en_req} = '0;
    paddr = '0;
    pwdata = '0;
    miscompares = 0;
    samples_checked = 0;
    n = $urandom(32'h2a40);
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check("reset value", rd, rst_tab[i]);
      check("slverr", {31'h0, er}, {31'h0, i == 5});
    end
    $display("test reset values done");
    rl = 16'h8000 + 16'($urandom % 32'h4000);
    apb(1'b1, `FSWDT_ADDR_RELOAD, {16'h0, rl});
    apb(1'b1, `FSWDT_ADDR_COUNT, 32'h0);
    cmd(1'b1, 1'b0, 1'b0);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    check("count load", rd, {16'h0, rl});
    repeat (868) @(posedge clk);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    check("count fast", rd, {16'h0, exp_cnt(rl, 3)});
    repeat (100) @(posedge clk);
    cmd(1'b1, 1'b0, 1'b0);
    repeat (150) @(posedge clk);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    check("prescaler clear", rd, {16'h0, rl});
    apb(1'b1, `FSWDT_ADDR_CTRL, 32'h1);
    cmd(1'b1, 1'b0, 1'b0);
    repeat (24000) @(posedge clk);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    check("count slow", rd, {16'h0, exp_cnt(rl, 1)});
    apb(1'b1, `FSWDT_ADDR_CTRL, 32'h0);
    $display("test prescaler done");
    cmd(1'b0, 1'b1, 1'b1);
    apb(1'b0, `FSWDT_ADDR_CTRL, 32'h0);
    check("disable wins", rd, 32'h0);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    keep = rd;
    repeat (600) @(posedge clk);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    check("count frozen", rd, keep);
    cmd(1'b0, 1'b0, 1'b1);
    apb(1'b0, `FSWDT_ADDR_CTRL, 32'h0);
    check("enable", rd, 32'h2);
    $display("test disable done");
    apb(1'b1, `FSWDT_ADDR_RELOAD, 32'hFFFE);
    auto_en <= 1'b1;
    n = 0;
    repeat (2000) begin
      @(posedge clk);
      n += (irq !== 1'b0);
    end
    check("serviced no irq", n, 0);
    auto_en <= 1'b0;
    $display("test service done");
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("prewarning", {31'h0, irq}, 32'h1);
    check("no early reset", {31'h0, rst_req}, 32'h0);
    n = 0;
    while (rst_req !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check("reset delay", n, 32'(`FSWDT_WARN_CYCLES) + 32'h1);
    apb(1'b0, `FSWDT_ADDR_STATUS, 32'h0);
    check("status", rd, 32'h3);
    apb(1'b0, `FSWDT_ADDR_COUNT, 32'h0);
    check("count wrap", rd, 32'hFFFE);
    cmd(1'b1, 1'b0, 1'b0);
    apb(1'b1, `FSWDT_ADDR_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check("masked irq", {31'h0, irq}, 32'h0);
    check("reset sticky", {31'h0, rst_req}, 32'h1);
    apb(1'b1, `FSWDT_ADDR_MASK, 32'h3);
    apb(1'b1, `FSWDT_ADDR_STATUS, 32'h1);
    apb(1'b0, `FSWDT_ADDR_STATUS, 32'h0);
    check("status clear", rd, 32'h2);
    check("irq level", {31'h0, irq}, 32'h1);
    $display("test overflow done");
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("reset cleared", {30'h0, rst_req, irq}, 32'h0);
    apb(1'b0, `FSWDT_ADDR_CTRL, 32'h0);
    check("enabled again", rd, 32'h2);
    $display("test second reset done");
    stop_test();
  end
endmodule : fswdt_top_test
